// ### rtl/ampcr_regs.sv
`timescale 1ns/1ns
`include "ampcr_cfg.svh"

module ampcr_regs
	import ampcr_pkg::*;
(
	input  wire logic            clk,                    // Device clock, 20 MHz
	input  wire logic            rst,                    // Sync reset, active high
	input  wire ampcr_req_type   req,                    // Register access from serial engine
	input  wire logic            overcurrent_autorecover, // Mode register bit, same clock
	input  wire logic            overtemp_autorecover,   // Mode register bit, same clock
	input  wire ampcr_fault_type fault_pin,              // Raw fault levels from analog
	output      logic [7:0]      rdata_q,                // Read data, one cycle after rd
	output      ampcr_level_type level_q,                // Level control settings
	output      logic            right_power_down_q,     // Right channel shut down
	output      logic            left_power_down_q,      // Left channel shut down
	output      ampcr_fault_type fault_q,                // Latched fault flags
	output      logic            recover_q               // Recovery pulse to analog
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	// Control state lives here; fault flags sit in the latch submodule
	// All outputs leave straight from registers, no logic after the flops

	// Next values of the output registers
	ampcr_level_type level_d;
	logic            right_power_down_d;
	logic            left_power_down_d;
	logic [7:0]      rdata_d;
	logic            recover_d;

	// Synchroniser stages
	ampcr_fault_type sync1_d;
	ampcr_fault_type sync1_q;
	ampcr_fault_type sync2_d;
	ampcr_fault_type sync2_q;

	// Decoded write strobes
	logic            wr_clear;
	logic            wr_reset;
	logic            wr_level;
	logic            wr_shutdown;
	logic            flag_clr;

	// Address match helper
	// Only writes match; reads go through the readback mux instead
	function automatic logic hit(input ampcr_req_type r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	// Byte returned to the host for an address
	// Write-only and unmapped addresses read as zero
	// Fault byte pads the upper nibble with zeros
	function automatic logic [7:0] readback(
		input logic [7:0]      a,    // Register address
		input ampcr_level_type lv,   // Level control settings
		input logic            rpd,  // Right channel shut down
		input logic            lpd,  // Left channel shut down
		input ampcr_fault_type ff    // Latched fault flags
	);
		case (a)
			`AMPCR_ADDR_LEVEL_CTRL:  readback = lv;
			`AMPCR_ADDR_SHUTDOWN:    readback = {6'h00, rpd, lpd};
			`AMPCR_ADDR_FAULT_FLAGS: readback = {4'h0, ff};
			default:                 readback = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Fault input synchroniser
	// Fault levels come from the analog side with no clock relation
	// Two stages before any logic reads them
	// A fault shorter than a cycle may be missed
	// Only the second stage feeds the flag latch

	// Next stage values
	always_comb begin
		sync1_d = fault_pin;
		sync2_d = sync1_q;
	end

	// Synchroniser stages
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= ampcr_fault_type'(`AMPCR_RST_FLAGS);
			sync2_q <= ampcr_fault_type'(`AMPCR_RST_FLAGS);
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write strobes

	// Clear and soft reset ignore the data byte
	// Neither register stores anything; a write is a one-cycle event
	assign wr_clear = hit(req, `AMPCR_ADDR_FAULT_CLEAR);
	assign wr_reset = hit(req, `AMPCR_ADDR_SOFT_RESET);
	assign flag_clr = wr_clear | wr_reset;                 // Soft reset clears flags too

	// Plain register writes
	// Writes to the fault address match nothing and are dropped
	assign wr_level    = hit(req, `AMPCR_ADDR_LEVEL_CTRL);
	assign wr_shutdown = hit(req, `AMPCR_ADDR_SHUTDOWN);

	////////////////////////////////////////////////////////////////////////////
	// Control register next values
	// Soft reset outranks a normal write in the same cycle
	// Only one address is decoded per request, so writes never collide
	// Registers hold their value when nothing addresses them
	// Reserved shutdown bits are dropped on write

	// Next values of the control registers
	always_comb begin
		level_d            = level_q;
		right_power_down_d = right_power_down_q;
		left_power_down_d  = left_power_down_q;
		if (wr_reset) begin
			level_d.level_ctrl_on         = `AMPCR_RST_LEVEL_ON;
			level_d.comp_mode             = ampcr_comp_type'(`AMPCR_RST_COMP);
			level_d.threshold_fixed_power = `AMPCR_RST_FIXED;
			level_d.threshold_level       = `AMPCR_RST_THRESHOLD;
			right_power_down_d            = `AMPCR_RST_POWER_DOWN;
			left_power_down_d             = `AMPCR_RST_POWER_DOWN;
		end else if (wr_level) begin
			level_d.level_ctrl_on         = req.wdata[`AMPCR_LC_ON_BIT];
			level_d.comp_mode             =
				ampcr_comp_type'(req.wdata[`AMPCR_LC_COMP_HI:`AMPCR_LC_COMP_LO]);
			level_d.threshold_fixed_power = req.wdata[`AMPCR_LC_FIXED_BIT];
			// Code passed straight through; analog maps it monotonically
			level_d.threshold_level       =
				req.wdata[`AMPCR_LC_THR_HI:`AMPCR_LC_THR_LO];
		end else if (wr_shutdown) begin
			right_power_down_d = req.wdata[`AMPCR_SD_RIGHT_BIT];
			left_power_down_d  = req.wdata[`AMPCR_SD_LEFT_BIT];
		end
	end

	// Control registers
	// Power-on values match the soft reset values above
	// Both channels start shut down
	// Write effects show one cycle after the request
	always_ff @(posedge clk) begin
		if (rst) begin
			level_q.level_ctrl_on         <= `AMPCR_RST_LEVEL_ON;
			level_q.comp_mode             <= ampcr_comp_type'(`AMPCR_RST_COMP);
			level_q.threshold_fixed_power <= `AMPCR_RST_FIXED;
			level_q.threshold_level       <= `AMPCR_RST_THRESHOLD;
			right_power_down_q            <= `AMPCR_RST_POWER_DOWN;
			left_power_down_q             <= `AMPCR_RST_POWER_DOWN;
		end else begin
			level_q            <= level_d;
			right_power_down_q <= right_power_down_d;
			left_power_down_q  <= left_power_down_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault flags
	// Flags are sticky; set wins when a fault and a clear meet
	// Autorecovery bits gate only the setting of flags
	// Existing flags stay until a clear or soft reset
	// Flags reach the output three cycles after the pin

	// Flag latch
	ampcr_fault_latch u_fault (
		.clk     (clk),
		.rst     (rst),
		.clr     (flag_clr),
		.oc_arm  (overcurrent_autorecover),
		.ot_arm  (overtemp_autorecover),
		.cond    (sync2_q),
		.flags_q (fault_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read data and recovery pulse
	// Read data holds its last value between reads
	// Recovery pulse is one cycle wide, one cycle after the clearing write
	// Analog side restarts a tripped channel on that pulse

	// Next read data and pulse
	always_comb begin
		rdata_d   = rdata_q;
		recover_d = flag_clr;
		if (req.rd) begin
			rdata_d = readback(req.addr, level_q, right_power_down_q,
				left_power_down_q, fault_q);
		end
	end

	// Read data and pulse registers
	// Read data resets to zero; soft reset leaves it alone
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q   <= 8'h00;
			recover_q <= 1'h0;
		end else begin
			rdata_q   <= rdata_d;
			recover_q <= recover_d;
		end
	end

endmodule // ampcr_regs

// ### rtl/ampcr_cfg.svh
`ifndef AMPCR_CFG_SVH
`define AMPCR_CFG_SVH

// Register addresses
`define AMPCR_ADDR_LEVEL_CTRL  8'h04
`define AMPCR_ADDR_SHUTDOWN    8'h05
`define AMPCR_ADDR_FAULT_FLAGS 8'h06
`define AMPCR_ADDR_FAULT_CLEAR 8'h07
`define AMPCR_ADDR_SOFT_RESET  8'h08

// Level control field positions
`define AMPCR_LC_ON_BIT        7
`define AMPCR_LC_COMP_HI       6
`define AMPCR_LC_COMP_LO       5
`define AMPCR_LC_FIXED_BIT     4
`define AMPCR_LC_THR_HI        3
`define AMPCR_LC_THR_LO        0

// Shutdown and fault field positions
`define AMPCR_SD_RIGHT_BIT     1
`define AMPCR_SD_LEFT_BIT      0
`define AMPCR_FF_RIGHT_OC_BIT  3
`define AMPCR_FF_LEFT_OC_BIT   2
`define AMPCR_FF_OT_WARN_BIT   1
`define AMPCR_FF_OT_ERR_BIT    0

// Reset values
`define AMPCR_RST_LEVEL_ON     1'h0
`define AMPCR_RST_COMP         2'h2
`define AMPCR_RST_FIXED        1'h0
`define AMPCR_RST_THRESHOLD    4'hb
`define AMPCR_RST_POWER_DOWN   1'h1
`define AMPCR_RST_FLAGS        4'h0

`endif

// ### rtl/ampcr_pkg.sv
package ampcr_pkg;

	// Compressor modes
	typedef enum logic [1:0] {
		AMPCR_LIMITER = 2'h0,
		AMPCR_COMP1   = 2'h1,
		AMPCR_COMP2   = 2'h2,
		AMPCR_COMP3   = 2'h3
	} ampcr_comp_type;

	// Level control register fields
	typedef struct packed {
		logic           level_ctrl_on;
		ampcr_comp_type comp_mode;
		logic           threshold_fixed_power;
		logic [3:0]     threshold_level;
	} ampcr_level_type;

	// Raw fault conditions from the analog side
	typedef struct packed {
		logic right_overcurrent;
		logic left_overcurrent;
		logic overtemp_warning;
		logic overtemp_error;
	} ampcr_fault_type;

	// Register access request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ampcr_req_type;

endpackage

// ### rtl/ampcr_fault_latch.sv
`timescale 1ns/1ns
`include "ampcr_cfg.svh"

// Sticky fault flag holder with set-over-clear priority
module ampcr_fault_latch
	import ampcr_pkg::*;
(
	input  wire logic            clk,       // Device clock
	input  wire logic            rst,       // Sync reset, active high
	input  wire logic            clr,       // Clear pulse (error clear or soft reset)
	input  wire logic            oc_arm,    // Overcurrent reporting armed
	input  wire logic            ot_arm,    // Overtemp reporting armed
	input  wire ampcr_fault_type cond,      // Synchronised fault conditions
	output      ampcr_fault_type flags_q    // Latched flags
);

	ampcr_fault_type flags_d;
	ampcr_fault_type set_v;

	// Set terms gated by the autorecovery controls
	always_comb begin
		set_v.right_overcurrent = cond.right_overcurrent & oc_arm;
		set_v.left_overcurrent  = cond.left_overcurrent & oc_arm;
		set_v.overtemp_warning  = cond.overtemp_warning & ot_arm;
		set_v.overtemp_error    = cond.overtemp_error & ot_arm;
		if (clr) begin
			flags_d = set_v;
		end else begin
			flags_d = flags_q | set_v;
		end
	end

	// Flag register
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_q <= ampcr_fault_type'(`AMPCR_RST_FLAGS);
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule // ampcr_fault_latch

// ### bench/ampcr_host.sv
`timescale 1ns/1ns
// Host stand-in issuing single-byte register requests
module ampcr_host
	import ampcr_pkg::*;
(
	input  wire logic [7:0] rdata, // Read data from device
	input  wire logic       clk,   // Device clock
	output ampcr_req_type   req    // Request to device
);
	initial req = '0;
	// One request per call, released with inverted payload
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		req <= {w, ~w, a, d};
		@(posedge clk);
		req <= {2'b00, ~a, ~d};
		#1;
		q = rdata;
	endtask
endmodule // ampcr_host

// ### bench/ampcr_regs_properties.sv
`timescale 1ns/1ns
// Port checks of the register bank
module ampcr_regs_properties
	import ampcr_pkg::*;
(
	input wire logic            clk,                     // Clock
	input wire logic            rst,                     // Reset
	input wire ampcr_req_type   req,                     // Request
	input wire logic            overcurrent_autorecover, // Arm
	input wire logic            overtemp_autorecover,    // Arm
	input wire ampcr_fault_type fault_pin,               // Raw faults
	input wire logic [7:0]      rdata_q,                 // Read data
	input wire ampcr_level_type level_q,                 // Level
	input wire logic            right_power_down_q,      // Right off
	input wire logic            left_power_down_q,       // Left off
	input wire ampcr_fault_type fault_q,                 // Flags
	input wire logic            recover_q                // Pulse
);
	// Clearing write seen
	wire clr = req.wr && (req.addr == 8'h07 || req.addr == 8'h08);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_LEVEL_WR: assert property (req.wr && req.addr == 8'h04 |=> level_q == $past(req.wdata))
		else $error("level write lost");
	AST_SD_WR: assert property (req.wr && req.addr == 8'h05 |=> {right_power_down_q, left_power_down_q} == $past(req.wdata[1:0]))
		else $error("shutdown write lost");
	AST_RO_HI: assert property (req.rd && req.addr == 8'h06 |=> rdata_q == {4'h0, $past(fault_q)})
		else $error("fault upper bits set");
	AST_CLR_PULSE: assert property (clr |=> recover_q)
		else $error("no recovery pulse");
	AST_NO_PULSE: assert property (!clr |=> !recover_q)
		else $error("stray recovery pulse");
	AST_SRST: assert property (req.wr && req.addr == 8'h08 |=> level_q == 8'h4b && right_power_down_q && left_power_down_q)
		else $error("soft reset incomplete");
	AST_OC_GATE: assert property ($rose(fault_q[3]) || $rose(fault_q[2]) |-> $past(overcurrent_autorecover))
		else $error("overcurrent flag unarmed");
	AST_OT_GATE: assert property ($rose(fault_q[1]) || $rose(fault_q[0]) |-> $past(overtemp_autorecover))
		else $error("overtemp flag unarmed");
	AST_LATCH: assert property (!clr |=> ($past(fault_q) & ~fault_q) == 4'h0)
		else $error("flag dropped");
	cover property (clr);
	cover property ($rose(fault_q[0]));
	cover property (req.rd && req.addr == 8'h06);
endmodule // ampcr_regs_properties

// ### bench/test_amp_control_register_bank.sv
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module test_amp_control_register_bank
	import ampcr_pkg::*;
;
	logic clk = 0, rst = 1, oc = 0, ot = 0, rpd, lpd, rec;
	logic [7:0] rdata_q, q;
	ampcr_fault_type fp = '0, fault_q;
	ampcr_level_type level_q;
	ampcr_req_type req;
	int err_total = 0, tests_run = 0, cyc = 0;
	ampcr_host host (.clk(clk), .rdata(rdata_q), .req(req));
	ampcr_regs DUT (.clk(clk), .rst(rst), .req(req), .overcurrent_autorecover(oc),
		.overtemp_autorecover(ot), .fault_pin(fp), .rdata_q(rdata_q), .level_q(level_q),
		.right_power_down_q(rpd), .left_power_down_q(lpd), .fault_q(fault_q), .recover_q(rec));
	// Clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task w(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task r(input logic [7:0] a);
		host.xfer(1'b0, a, 8'h00, q);
	endtask
	task t_level;
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = {i[0], i[1:0], i[0], 4'(i * 5)};
			w(8'h04, v);
			`CHK(level_q, v)
			r(8'h04);
			`CHK(q, v)
		end
	endtask
	task t_fault;
		@(posedge clk);
		fp <= 4'hf;
		repeat (5) @(posedge clk);
		#1;
		`CHK(fault_q, 4'h0)
		@(posedge clk);
		oc <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK(fault_q, 4'hc)
		@(posedge clk);
		ot <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK(fault_q, 4'hf)
		@(posedge clk);
		fp <= 4'h0;
		w(8'h06, 8'h00);
		`CHK(fault_q, 4'hf)
		r(8'h06);
		`CHK(q, 8'h0f)
		w(8'h07, 8'h00);
		`CHK({rec, fault_q}, 5'h10)
	endtask
	task t_srst;
		w(8'h04, 8'h00);
		w(8'h05, 8'h00);
		@(posedge clk);
		fp <= 4'h2;
		@(posedge clk);
		fp <= 4'h0;
		repeat (4) @(posedge clk);
		#1;
		`CHK(fault_q, 4'h2)
		w(8'h08, 8'h00);
		`CHK({rec, fault_q, level_q, rpd, lpd}, 15'h412f)
	endtask
	task t_refuse;
		r(8'h07);
		`CHK(q, 8'h00)
		r(8'h08);
		`CHK(q, 8'h00)
		@(posedge clk);
		fp <= 4'h1;
		repeat (4) @(posedge clk);
		#1;
		`CHK(fault_q, 4'h1)
		w(8'h07, 8'h00);
		`CHK({rec, fault_q}, 5'h11)
		@(posedge clk);
		fp <= 4'h0;
		oc <= 1'b0;
		ot <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		`CHK(fault_q, 4'h1)
		w(8'h07, 8'h00);
		`CHK({rec, fault_q}, 5'h10)
	endtask
	task stop_test;
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(level_q, 8'h4b)
		`CHK({rpd, lpd}, 2'h3)
		r(8'h06);
		`CHK(q, 8'h00)
		t_level();
		w(8'h05, 8'hfe);
		`CHK({rpd, lpd}, 2'h2)
		w(8'h05, 8'h01);
		`CHK({rpd, lpd}, 2'h1)
		t_fault();
		t_srst();
		t_refuse();
		stop_test();
	end
endmodule // test_amp_control_register_bank
bind ampcr_regs ampcr_regs_properties chk (.clk(clk), .rst(rst), .req(req),
	.overcurrent_autorecover(overcurrent_autorecover), .fault_pin(fault_pin),
	.overtemp_autorecover(overtemp_autorecover), .rdata_q(rdata_q), .level_q(level_q),
	.right_power_down_q(right_power_down_q), .left_power_down_q(left_power_down_q),
	.fault_q(fault_q), .recover_q(recover_q));
